// ---- rtl/boot_decode_pkg.sv ----
// Package holding register map, field positions, reset values and timing constants.
// Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
package boot_decode_pkg;

  // Register word offsets; the byte address is four times the index.
  localparam logic [7:0] ROM_BASE_LOW_IDX   = 8'h30;
  localparam logic [7:0] ROM_BASE_HIGH_IDX  = 8'h32;
  localparam logic [7:0] ROM_MASK_LOW_IDX   = 8'h34;
  localparam logic [7:0] ROM_MASK_HIGH_IDX  = 8'h36;
  localparam logic [7:0] IO_BASE_IDX        = 8'h20;
  localparam logic [7:0] STATUS_IDX         = 8'h38;

  // Host address and window geometry.
  localparam int          HOST_ADDR_W       = 20;
  localparam int          ROM_IGNORE_BITS   = 12;
  localparam int          IO_ADDR_W         = 16;
  localparam int          IO_IGNORE_BITS    = 4;
  localparam logic [15:0] IO_BASE_RESET     = 16'h0300;
  localparam logic [15:0] REG_RESET         = 16'h0000;

  // Status register bit positions.
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_LINK_BIT  = 1;
  localparam int ST_TRAF_BIT  = 2;
  localparam int ST_CFG_BIT   = 3;

  // Link pulse is considered lost after this silence, traffic lamp stretched this long.
  localparam int LINK_TIMEOUT_MS    = 50;
  localparam int TRAFFIC_STRETCH_MS = 10;
  localparam int CLK_KHZ            = 50000;
  localparam int LINK_TIMEOUT_CYC   = LINK_TIMEOUT_MS * CLK_KHZ;
  localparam int TRAFFIC_CYC        = TRAFFIC_STRETCH_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    ARM_IDLE = 2'b00,
    ARM_ONE  = 2'b01,
    ARM_DONE = 2'b11
  } arm_state_type;

  typedef struct packed {
    logic [19:0] base;
    logic [19:0] mask;
    logic        armed;
  } rom_decode_type;

endpackage

// ---- rtl/activity_stretch.sv ----
// Pulse stretcher: holds an active-low lamp output for a count after its last event.
// Assumes the event input is already in the sys_clk domain.
`timescale 1ns/1ns
module activity_stretch #(
  parameter int COUNT = 1000
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Event in, lamp out.
  input  wire logic event_in,
  output logic      lamp_n
);

  logic [31:0] cnt_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 32'h0;
    end else if (event_in) begin
      cnt_q <= 32'(COUNT);
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lamp_n <= 1'b1;
    end else begin
      lamp_n <= !(event_in || cnt_q > 32'h1);
    end
  end

endmodule

// ---- rtl/boot_rom_decode_and_leds.sv ----
// Boot ROM address decoder, default I/O window decoder and activity lamps.
// Assumes a classic Wishbone master, ISA address lines and line events arriving asynchronously.
`timescale 1ns/1ns
// Operation
// - Writable 20-bit boot ROM base register
// - Writable boot ROM mask register
// - Low 12 mask bits ignored
// - No select until both registers written
// - Masked address match asserts select low
// - Link lamp active while pulses seen
// - Traffic lamp on transmit, receive, collision
// - Default I/O window 0300h after reset
// - I/O compare ignores lowest 4 bits
module boot_rom_decode_and_leds #(
  parameter int LINK_TIMEOUT = boot_decode_pkg::LINK_TIMEOUT_CYC,
  parameter int TRAFFIC_HOLD = boot_decode_pkg::TRAFFIC_CYC
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // ISA side.
  input  wire logic [19:0] isa_addr,
  input  wire logic        eeprom_cfg_valid,
  input  wire logic [15:0] eeprom_io_base,
  output logic             boot_rom_select_n,
  output logic             io_window_hit,
  // Line events.
  input  wire logic        link_pulse,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        collision,
  output logic             link_indicator_n,
  output logic             traffic_indicator_n
);

  // Two-stage synchronisers for all asynchronous inputs.
  // Each bit is synchronised on its own, so a word in motion may decode wrongly for a cycle;
  // the host must hold its address for longer than the three-edge decode latency.
  localparam int SYNC_W = 20 + 1 + 16 + 4;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {isa_addr, eeprom_cfg_valid, eeprom_io_base,
                  link_pulse, tx_active, rx_active, collision};
      sync2_q <= sync1_q;
    end
  end

  logic [19:0] addr_s;
  logic        cfg_s;
  logic [15:0] cfg_base_s;
  logic        link_s;
  logic        tx_s;
  logic        rx_s;
  logic        col_s;
  assign {addr_s, cfg_s, cfg_base_s, link_s, tx_s, rx_s, col_s} = sync2_q;

  // Register bus decode.
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    return adr == {idx, 2'b00};
  endfunction

  logic req;
  logic wr;
  logic mapped;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr  = req && wb_we_i;
  assign mapped = hit(wb_adr_i, boot_decode_pkg::ROM_BASE_LOW_IDX)
               || hit(wb_adr_i, boot_decode_pkg::ROM_BASE_HIGH_IDX)
               || hit(wb_adr_i, boot_decode_pkg::ROM_MASK_LOW_IDX)
               || hit(wb_adr_i, boot_decode_pkg::ROM_MASK_HIGH_IDX)
               || hit(wb_adr_i, boot_decode_pkg::IO_BASE_IDX)
               || hit(wb_adr_i, boot_decode_pkg::STATUS_IDX);

  // Registers are 16 bits wide in the low lanes; lanes 0 and 1 are honoured.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // Either half of a word pair counts as loading that pair.
  function automatic logic base_word(input logic [9:0] adr);
    return hit(adr, boot_decode_pkg::ROM_BASE_LOW_IDX)
        || hit(adr, boot_decode_pkg::ROM_BASE_HIGH_IDX);
  endfunction

  function automatic logic mask_word(input logic [9:0] adr);
    return hit(adr, boot_decode_pkg::ROM_MASK_LOW_IDX)
        || hit(adr, boot_decode_pkg::ROM_MASK_HIGH_IDX);
  endfunction

  logic [15:0] base_lo_q;
  logic [15:0] base_hi_q;
  logic [15:0] mask_lo_q;
  logic [15:0] mask_hi_q;
  logic [15:0] io_base_q;
  logic        base_wr_q;
  logic        mask_wr_q;
  logic        io_written_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      base_lo_q <= boot_decode_pkg::REG_RESET;
      base_hi_q <= boot_decode_pkg::REG_RESET;
    end else if (wr && hit(wb_adr_i, boot_decode_pkg::ROM_BASE_LOW_IDX)) begin
      base_lo_q <= merge(base_lo_q, wb_dat_i, wb_sel_i);
    end else if (wr && hit(wb_adr_i, boot_decode_pkg::ROM_BASE_HIGH_IDX)) begin
      base_hi_q <= merge(base_hi_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_lo_q <= boot_decode_pkg::REG_RESET;
      mask_hi_q <= boot_decode_pkg::REG_RESET;
    end else if (wr && hit(wb_adr_i, boot_decode_pkg::ROM_MASK_LOW_IDX)) begin
      mask_lo_q <= merge(mask_lo_q, wb_dat_i, wb_sel_i);
    end else if (wr && hit(wb_adr_i, boot_decode_pkg::ROM_MASK_HIGH_IDX)) begin
      mask_hi_q <= merge(mask_hi_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      base_wr_q <= 1'b0;
      mask_wr_q <= 1'b0;
    end else begin
      if (wr && (hit(wb_adr_i, boot_decode_pkg::ROM_BASE_LOW_IDX)
              || hit(wb_adr_i, boot_decode_pkg::ROM_BASE_HIGH_IDX))) begin
        base_wr_q <= 1'b1;
      end
      if (wr && (hit(wb_adr_i, boot_decode_pkg::ROM_MASK_LOW_IDX)
              || hit(wb_adr_i, boot_decode_pkg::ROM_MASK_HIGH_IDX))) begin
        mask_wr_q <= 1'b1;
      end
    end
  end

  // arming state machine
  // Gray steps keep one bit moving, so a read of the armed flag never sees a false state.
  boot_decode_pkg::arm_state_type arm_q;
  boot_decode_pkg::arm_state_type arm_d;
  logic                           base_wr_now;
  logic                           mask_wr_now;
  assign base_wr_now = wr && base_word(wb_adr_i);
  assign mask_wr_now = wr && mask_word(wb_adr_i);

  always_comb begin
    arm_d = arm_q;
    case (arm_q)
      boot_decode_pkg::ARM_IDLE: begin
        if (base_wr_now || mask_wr_now) begin
          arm_d = boot_decode_pkg::ARM_ONE;
        end
      end
      boot_decode_pkg::ARM_ONE: begin
        if ((base_wr_q && mask_wr_now) || (mask_wr_q && base_wr_now)) begin
          arm_d = boot_decode_pkg::ARM_DONE;
        end
      end
      boot_decode_pkg::ARM_DONE: begin
        arm_d = boot_decode_pkg::ARM_DONE;
      end
      default: begin
        arm_d = boot_decode_pkg::ARM_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      arm_q <= boot_decode_pkg::ARM_IDLE;
    end else begin
      arm_q <= arm_d;
    end
  end

  // I/O base: an EEPROM configuration replaces the default until software writes it, and a software write always wins.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_written_q <= 1'b0;
      io_base_q    <= boot_decode_pkg::IO_BASE_RESET;
    end else if (wr && hit(wb_adr_i, boot_decode_pkg::IO_BASE_IDX)) begin
      io_written_q <= 1'b1;
      io_base_q    <= merge(io_base_q, wb_dat_i, wb_sel_i);
    end else if (cfg_s && !io_written_q) begin
      io_base_q    <= cfg_base_s;
    end
  end

  // Decode, with values carried together.
  boot_decode_pkg::rom_decode_type dec;
  assign dec.base  = {base_hi_q[3:0], base_lo_q};
  assign dec.mask  = {mask_hi_q[3:0], mask_lo_q[15:12], 12'h000};
  assign dec.armed = arm_q == boot_decode_pkg::ARM_DONE;

  logic rom_match;
  assign rom_match = ((addr_s ^ dec.base) & dec.mask) == 20'h00000;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boot_rom_select_n <= 1'b1;
    end else begin
      boot_rom_select_n <= !(dec.armed && rom_match);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_window_hit <= 1'b0;
    end else begin
      io_window_hit <= addr_s[15:4] == io_base_q[15:4];
    end
  end

  activity_stretch #(
    .COUNT(LINK_TIMEOUT)
  ) u_link (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .event_in(link_s),
    .lamp_n  (link_indicator_n)
  );

  activity_stretch #(
    .COUNT(TRAFFIC_HOLD)
  ) u_traffic (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .event_in(tx_s || rx_s || col_s),
    .lamp_n  (traffic_indicator_n)
  );

  // Bus answer: one cycle after the request is seen, ack or err for one cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      if (hit(wb_adr_i, boot_decode_pkg::ROM_BASE_LOW_IDX)) begin
        wb_dat_o <= {16'h0, base_lo_q};
      end else if (hit(wb_adr_i, boot_decode_pkg::ROM_BASE_HIGH_IDX)) begin
        wb_dat_o <= {16'h0, base_hi_q};
      end else if (hit(wb_adr_i, boot_decode_pkg::ROM_MASK_LOW_IDX)) begin
        wb_dat_o <= {16'h0, mask_lo_q};
      end else if (hit(wb_adr_i, boot_decode_pkg::ROM_MASK_HIGH_IDX)) begin
        wb_dat_o <= {16'h0, mask_hi_q};
      end else if (hit(wb_adr_i, boot_decode_pkg::IO_BASE_IDX)) begin
        wb_dat_o <= {16'h0, io_base_q};
      end else if (hit(wb_adr_i, boot_decode_pkg::STATUS_IDX)) begin
        wb_dat_o <= {28'h0, cfg_s, !traffic_indicator_n, !link_indicator_n, dec.armed};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // Checks.
  select_unarmed_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !dec.armed |=> boot_rom_select_n)
    else $error("boot ROM selected before both registers written");
  select_match_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    dec.armed && rom_match |=> !boot_rom_select_n)
    else $error("select missing on masked match");
  select_miss_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !rom_match |=> boot_rom_select_n)
    else $error("select asserted without match");
  mask_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    dec.armed && (((addr_s[19:12] ^ dec.base[19:12]) & {mask_hi_q[3:0], mask_lo_q[15:12]})
    == 8'h00) |=> !boot_rom_select_n)
    else $error("low address or mask bits used in compare");
  base_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr && hit(wb_adr_i, boot_decode_pkg::ROM_BASE_LOW_IDX) && wb_sel_i[1:0] == 2'b11
    |=> base_lo_q == $past(wb_dat_i[15:0]))
    else $error("base low word not stored");
  mask_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr && hit(wb_adr_i, boot_decode_pkg::ROM_MASK_HIGH_IDX) && wb_sel_i[1:0] == 2'b11
    |=> mask_hi_q == $past(wb_dat_i[15:0]) ##1 mask_wr_q)
    else $error("mask high word not stored");
  link_lamp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    link_s |=> !link_indicator_n)
    else $error("link lamp off while pulses seen");
  traffic_lamp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tx_s || rx_s || col_s) |=> !traffic_indicator_n)
    else $error("traffic lamp off during activity");
  io_window_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    addr_s[15:4] == io_base_q[15:4] |=> io_window_hit)
    else $error("I/O window miss on aligned match");
  io_default_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !io_written_q && !cfg_s && $stable(cfg_s) |-> io_base_q == 16'h0300)
    else $error("default I/O base lost");
  cfg_base_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfg_s && !io_written_q && !(wr && hit(wb_adr_i, boot_decode_pkg::IO_BASE_IDX))
    |=> io_base_q == $past(cfg_base_s))
    else $error("configured I/O base not taken");
  io_miss_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    addr_s[15:4] != io_base_q[15:4] |=> !io_window_hit)
    else $error("I/O window hit without aligned match");
  select_armed_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(boot_rom_select_n) |-> $past(dec.armed))
    else $error("select fell while decode unarmed");
  arm_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    dec.armed |=> dec.armed)
    else $error("decode disarmed without reset");

  arm_c: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(dec.armed));
  select_c: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(boot_rom_select_n));
  err_c: cover property (@(posedge sys_clk) disable iff (!resetn) wb_err_o);
  traffic_c: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(traffic_indicator_n));
  io_c: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(io_window_hit));

endmodule

// ---- test/rom_partner.sv ----
// Model of the external boot ROM and of the host memory address lines.
// Assumes the decoder select is active low and that the bench calls drive once per address.
`timescale 1ns/1ns
module rom_partner (
  // Clock.
  input  wire logic        sys_clk,
  // Decoder side.
  input  wire logic        boot_rom_select_n,
  output logic [19:0]      isa_addr,
  output logic [7:0]       rom_data
);
  logic [7:0] idle_q = 8'h00;

  initial begin
    isa_addr = 20'h00000;
  end

  // Unselected, the data lines wander so a stale byte never passes for ROM output.
  always @(posedge sys_clk) begin
    idle_q <= ~idle_q;
  end

  assign rom_data = boot_rom_select_n ? idle_q : (isa_addr[7:0] ^ 8'h5A);

  task automatic drive(input logic [19:0] addr);
    @(posedge sys_clk);
    isa_addr <= addr;
  endtask
endmodule

// ---- test/boot_rom_decode_and_leds_bench.sv ----
// Self-checking bench for the boot ROM decoder, the I/O window and the lamps.
// Assumes a Wishbone answer one cycle after take and three edges from input to output.
`timescale 1ns/1ns
module boot_rom_decode_and_leds_bench;
  localparam int LINK_T = 8;
  localparam int TRAF_T = 4;
  logic        sys_clk      = 1'b0;
  logic        resetn       = 1'b0;
  logic        wb_cyc       = 1'b0;
  logic        wb_stb       = 1'b0;
  logic        wb_we        = 1'b0;
  logic [9:0]  wb_adr       = 10'h000;
  logic [31:0] wb_dat       = 32'h00000000;
  logic [3:0]  wb_sel       = 4'h3;
  logic        eeprom_valid = 1'b0;
  logic [15:0] eeprom_base  = 16'h0000;
  logic        link_p       = 1'b0;
  logic        tx           = 1'b0;
  logic        rx           = 1'b0;
  logic        coll         = 1'b0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        wb_err;
  logic [19:0] isa_addr;
  logic        sel_n;
  logic        io_hit;
  logic        link_n;
  logic        traf_n;
  logic [7:0]  rom_data;
  logic [31:0] rd;
  logic        er;
  int          failures     = 0;
  int          checked      = 0;

  always #10 sys_clk = ~sys_clk;

  boot_rom_decode_and_leds #(
    .LINK_TIMEOUT (LINK_T),
    .TRAFFIC_HOLD (TRAF_T)
  ) boot_rom_decode_and_leds_inst (
    .sys_clk             (sys_clk),
    .resetn              (resetn),
    .wb_cyc_i            (wb_cyc),
    .wb_stb_i            (wb_stb),
    .wb_we_i             (wb_we),
    .wb_adr_i            (wb_adr),
    .wb_sel_i            (wb_sel),
    .wb_dat_i            (wb_dat),
    .wb_dat_o            (wb_rdat),
    .wb_ack_o            (wb_ack),
    .wb_err_o            (wb_err),
    .isa_addr            (isa_addr),
    .eeprom_cfg_valid    (eeprom_valid),
    .eeprom_io_base      (eeprom_base),
    .boot_rom_select_n   (sel_n),
    .io_window_hit       (io_hit),
    .link_pulse          (link_p),
    .tx_active           (tx),
    .rx_active           (rx),
    .collision           (coll),
    .link_indicator_n    (link_n),
    .traffic_indicator_n (traf_n)
  );

  rom_partner rom_partner_inst (
    .sys_clk           (sys_clk),
    .boot_rom_select_n (sel_n),
    .isa_addr          (isa_addr),
    .rom_data          (rom_data)
  );

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [31:0] wd,
                         output logic [31:0] rdat, output logic erf);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    @(posedge sys_clk);
    while (wb_ack !== 1'b1 && wb_err !== 1'b1) begin
      n++;
      if (n > 16) begin
        failures++;
        final_report;
      end
      @(posedge sys_clk);
    end
    rdat = wb_rdat;
    erf = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic probe(input logic [19:0] a, input logic sel_exp, input logic hit_exp);
    rom_partner_inst.drive(a);
    tick(4);
    check({31'h0, sel_n}, {31'h0, sel_exp});
    check({31'h0, io_hit}, {31'h0, hit_exp});
    if (sel_exp === 1'b0) check({24'h0, rom_data}, {24'h0, a[7:0] ^ 8'h5A});
  endtask

  task automatic t_defaults;
    check({30'h0, link_n, traf_n}, 32'h3);
    wb_xfer(1'b0, 10'h0C0, 32'h0, rd, er);
    check(rd, 32'h0);
    wb_xfer(1'b0, 10'h3FC, 32'h0, rd, er);
    check({31'h0, er}, 32'h1);
    probe(20'h002FF, 1'b1, 1'b0);
    probe(20'h00300, 1'b1, 1'b1);
    probe(20'h0030F, 1'b1, 1'b1);
    probe(20'h00310, 1'b1, 1'b0);
    probe(20'h00000, 1'b1, 1'b0);
  endtask

  task automatic t_arm;
    wb_xfer(1'b1, 10'h0C0, 32'h0000, rd, er);
    wb_xfer(1'b1, 10'h0C8, 32'h000D, rd, er);
    probe(20'hD0000, 1'b1, 1'b0);
    // Low mask bits set on purpose: the decoder must not honour them.
    wb_xfer(1'b1, 10'h0D0, 32'hCFFF, rd, er);
    wb_xfer(1'b1, 10'h0D8, 32'h000F, rd, er);
    wb_xfer(1'b0, 10'h0C8, 32'h0, rd, er);
    check(rd, 32'h0000000D);
    wb_xfer(1'b0, 10'h0D8, 32'h0, rd, er);
    check(rd, 32'h0000000F);
    wb_xfer(1'b0, 10'h0E0, 32'h0, rd, er);
    check(rd, 32'h00000001);
    probe(20'hD0000, 1'b0, 1'b0);
    probe(20'hD3ABC, 1'b0, 1'b0);
    probe(20'hD4000, 1'b1, 1'b0);
    probe(20'hCFFFF, 1'b1, 1'b0);
  endtask

  task automatic t_rearm;
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    probe(20'hD0000, 1'b1, 1'b0);
    probe(20'h00305, 1'b1, 1'b1);
  endtask

  task automatic t_eeprom;
    eeprom_valid <= 1'b1;
    eeprom_base  <= 16'h0340;
    tick(4);
    probe(20'h0034F, 1'b1, 1'b1);
    probe(20'h00300, 1'b1, 1'b0);
    wb_xfer(1'b0, 10'h0E0, 32'h0, rd, er);
    check(rd, 32'h00000008);
    wb_xfer(1'b1, 10'h080, 32'h0360, rd, er);
    probe(20'h0036A, 1'b1, 1'b1);
    probe(20'h0034F, 1'b1, 1'b0);
    wb_sel <= 4'h1;
    wb_xfer(1'b1, 10'h080, 32'hFFAB, rd, er);
    wb_sel <= 4'h3;
    wb_xfer(1'b0, 10'h080, 32'h0, rd, er);
    check(rd, 32'h000003AB);
  endtask

  task automatic t_lamps;
    link_p <= 1'b1;
    tick(1);
    link_p <= 1'b0;
    tick(3);
    check({31'h0, link_n}, 32'h0);
    tick(LINK_T + 4);
    check({31'h0, link_n}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      {coll, rx, tx} <= 3'b001 << i;
      tick(1);
      {coll, rx, tx} <= 3'b000;
      tick(3);
      check({31'h0, traf_n}, 32'h0);
      tick(TRAF_T + 4);
      check({31'h0, traf_n}, 32'h1);
    end
  endtask

  initial begin
    tick(20);
    resetn <= 1'b1;
    t_defaults;
    t_arm;
    t_rearm;
    t_eeprom;
    t_lamps;
    final_report;
  end
endmodule
